// ### dv/eisc_far_model.sv
// Far side of the interrupt block: pins, event lines, watchdog, core acks.
// Assumes the bench calls its tasks from one process at a time.
`timescale 1ns/10ps
`default_nettype none
module eisc_far_model (
  input wire logic clk_in, // Core clock
  output logic [7:0] ext_pin_out, // External channel lines
  output logic [8:0] std_line_out, // Standard channel lines
  output logic nmi_out, // Non-maskable pin
  output logic wdg_out, // Watchdog end-of-count
  output logic [7:0] ext_ack_out, // External acknowledges
  output logic [8:0] std_ack_out, // Standard acknowledges
  output logic tl_ack_out // Top-level acknowledge
);
  // Idle levels at time zero
  initial begin
    {ext_pin_out, std_line_out, nmi_out, wdg_out} = '0;
    {ext_ack_out, std_ack_out, tl_ack_out} = '0;
  end
  // level hold time
  // Six cycles outlasts the synchroniser, so no edge can be lost
  task automatic set_lines(input logic [7:0] e, input logic [8:0] s,
                           input logic n);
    @(negedge clk_in);
    ext_pin_out = e;
    std_line_out = s;
    nmi_out = n;
    repeat (6) @(negedge clk_in);
  endtask
  // Acknowledge strobes last one cycle, as in the machine cycle
  task automatic ack(input logic [7:0] e, input logic [8:0] s,
                     input logic t);
    @(negedge clk_in);
    {ext_ack_out, std_ack_out, tl_ack_out} = {e, s, t};
    @(negedge clk_in);
    {ext_ack_out, std_ack_out, tl_ack_out} = '0;
  endtask
  // Watchdog end of count is a single-cycle pulse
  task automatic wdg_pulse;
    @(negedge clk_in);
    wdg_out = 1'b1;
    @(negedge clk_in);
    wdg_out = 1'b0;
  endtask
endmodule
`default_nettype wire

// ### dv/eisc_irq_ctrl_bench.sv
// Self-checking bench for the interrupt channel block with a bit model.
// Assumes eisc_far_model drives pins and acks; bench drives at negedge.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
  num_errors++; $display("BAD %s exp %0h got %0h", n, e, g); end end
module eisc_irq_ctrl_bench;
  import eisc_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, wr_s = 1'b0, rd_s = 1'b0;
  logic [7:0] page, addr, wdata, rdata, ereq, epin, eack, d, e, m_ep, m_em;
  logic [8:0] sreq, sline, sack, m_sp, m_sm, se;
  logic wait_n, gie, tlen, tl_set, nested, pre, pre_tl, iret;
  logic nmi, wdg, tlack, tlreq, tlpend, tick, stretch;
  logic [2:0] plevel, ilevel, best;
  logic [23:0] prio;
  logic [6:0] hold;
  logic [7:0] tab [11];
  int num_errors = 0, num_checks = 0, seed = 5, i, j, k, lv, bl;

  always #4 clk = ~clk;

  eisc_irq_ctrl dut_u (.MCLK_IN(clk), .RSTN_IN(rst_n), .REG_PAGE_IN(page),
    .REG_ADDR_IN(addr), .REG_WR_IN(wr_s), .REG_RD_IN(rd_s),
    .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata), .EXT_PIN_IN(epin),
    .STD_LINE_IN(sline), .NMI_PIN_IN(nmi), .MEM_WAIT_N_IN(wait_n),
    .WDG_EOC_IN(wdg), .GLOBAL_IRQ_EN_IN(gie), .TOPLEVEL_EN_IN(tlen),
    .TL_SW_SET_IN(tl_set), .TL_ACK_IN(tlack), .EXT_ACK_IN(eack),
    .STD_ACK_IN(sack), .NESTED_MODE_IN(nested), .PREEMPT_IN(pre),
    .PREEMPT_BY_TL_IN(pre_tl), .PREEMPT_LEVEL_IN(plevel), .IRET_IN(iret),
    .IRET_LEVEL_IN(ilevel), .EXT_REQ_OUT(ereq), .STD_REQ_OUT(sreq),
    .EXT_PRIO_OUT(prio), .EXT_BEST_LEVEL_OUT(best), .TL_REQ_OUT(tlreq),
    .TL_PENDING_OUT(tlpend), .HOLD_LEVEL_OUT(hold),
    .SAMPLE_TICK_OUT(tick), .MEM_STRETCH_OUT(stretch));

  eisc_far_model far (.clk_in(clk), .ext_pin_out(epin),
    .std_line_out(sline), .nmi_out(nmi), .wdg_out(wdg),
    .ext_ack_out(eack), .std_ack_out(sack), .tl_ack_out(tlack));

  // Verdict and end of run
  task automatic summarize;
    if (num_errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // One-cycle write strobe
  task automatic wr(input logic [7:0] pg, a, v);
    @(negedge clk);
    {page, addr, wdata, wr_s} = {pg, a, v, 1'b1};
    @(negedge clk);
    wr_s = 1'b0;
  endtask
  // Read data holds until the next read, so sample a cycle late
  task automatic rd(input logic [7:0] pg, a, output logic [7:0] v);
    @(negedge clk);
    {page, addr, rd_s} = {pg, a, 1'b1};
    @(negedge clk);
    rd_s = 1'b0;
    @(negedge clk);
    v = rdata;
  endtask
  task automatic chk_rd(input string n, input logic [7:0] pg, a, x);
    logic [7:0] v;
    rd(pg, a, v);
    `CHK(n, x, v)
  endtask
  task automatic wr9(input logic [7:0] ah, al, input logic [8:0] v);
    wr(PAGE_STD, al, v[7:0]);
    wr(PAGE_STD, ah, {7'h00, v[8]});
  endtask
  // Requests move only on ticks: let two ticks pass, bounded
  task automatic wait2;
    int n;
    n = 0;
    for (int c = 0; c < 14 && n < 2; c++) begin
      @(negedge clk);
      if (tick === 1'b1) n++;
    end
    @(negedge clk);
    if (n < 2) begin
      num_errors++;
      summarize();
    end
  endtask
  task automatic chk_ext;
    rd(PAGE_EXT, OFS_EXT_PEND, d);
    `CHK("ext_pend", m_ep, d)
    `CHK("ext_req", gie ? m_ep & m_em : 8'h00, ereq)
  endtask
  task automatic chk_std;
    rd(PAGE_STD, OFS_STD_PEND_L, d);
    `CHK("std_pend_l", m_sp[7:0], d)
    rd(PAGE_STD, OFS_STD_PEND_H, d);
    `CHK("std_pend_h", {7'h00, m_sp[8]}, d)
    `CHK("std_req", m_sp & m_sm, sreq)
  endtask
  // Core preempt or iret strobe
  task automatic core_evt(input logic [2:0] l, input logic t, r);
    @(negedge clk);
    {plevel, ilevel, pre_tl, pre, iret} = {l, l, t, !r, r};
    @(negedge clk);
    {pre, iret} = 2'b00;
    @(negedge clk);
  endtask

  initial begin
    {page, addr, wdata, plevel, ilevel} = '0;
    {wait_n, gie, tlen, tl_set, nested, pre, pre_tl, iret} = 8'h80;
    {m_ep, m_em, m_sp, m_sm} = '0;
    tab = '{OFS_EXT_EDGE, OFS_EXT_PEND, OFS_EXT_PRIO, OFS_EXT_MASK, OFS_NEST,
      OFS_STD_MASK_H, OFS_STD_MASK_L, OFS_STD_EDGE_H, OFS_STD_EDGE_L,
      OFS_STD_PEND_H, OFS_STD_PEND_L};
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    // Reset state of levels, registers and page steering
    for (i = 0; i < 8; i++)
      `CHK("prio_rst", 3'(6 + i % 2), prio[3*i +: 3])
    `CHK("best_rst", LEVEL_LOWEST, best)
    for (i = 0; i < 11; i++)
      chk_rd("reg_rst", i < 5 ? PAGE_EXT : PAGE_STD, tab[i],
        i == 2 ? RST_EXT_PRIO : 8'h00);
    rd(PAGE_EXT, OFS_EXT_VEC, d);
    `CHK("cfg_rst", RST_EXT_CFG, d[3:0])
    chk_rd("unmapped", PAGE_EXT, 8'hfb, 8'h00);
    wr(PAGE_STD, OFS_EXT_MASK, 8'hff);
    chk_rd("page", PAGE_EXT, OFS_EXT_MASK, 8'h00);
    k = 0;
    repeat (50) begin
      @(negedge clk);
      if (tick === 1'b1) k++;
    end
    `CHK("ticks", 10, k)
    // Each external channel: selected edge sets, other edge does not
    gie = 1'b1;
    for (i = 0; i < 8; i++) begin
      e = $random(seed);
      m_em = 8'h01 << i;
      wr(PAGE_EXT, OFS_EXT_EDGE, e);
      wr(PAGE_EXT, OFS_EXT_MASK, m_em);
      far.set_lines(8'h01 << i, 9'h000, 1'b0);
      wait2();
      m_ep[i] = e[i];
      chk_ext();
      far.set_lines(8'h00, 9'h000, 1'b0);
      wait2();
      m_ep[i] = 1'b1;
      chk_ext();
      far.ack(8'h01 << i, 9'h000, 1'b0);
      m_ep = 8'h00;
      wait2();
      chk_ext();
    end
    // Random software pendings, masks, enable and pair priorities
    for (j = 0; j < 4; j++) begin
      {m_ep, m_em, e} = $random(seed);
      gie = j[0];
      wr(PAGE_EXT, OFS_EXT_PRIO, e);
      wr(PAGE_EXT, OFS_EXT_MASK, m_em);
      wr(PAGE_EXT, OFS_EXT_PEND, m_ep);
      wait2();
      chk_ext();
      bl = 7;
      for (i = 0; i < 8; i++) begin
        lv = ((e >> (i / 2 * 2)) & 3) * 2 + i % 2;
        `CHK("prio", 3'(lv), prio[3*i +: 3])
        if (gie && m_ep[i] && m_em[i] && lv < bl) bl = lv;
      end
      `CHK("best", 3'(bl), best)
    end
    wr(PAGE_EXT, OFS_EXT_PEND, 8'h00);
    {m_ep, m_em, gie} = {8'h00, 8'hff, 1'b1};
    wr(PAGE_EXT, OFS_EXT_MASK, m_em);
    // watchdog to top level only, A0 from pin
    wr(PAGE_EXT, OFS_EXT_VEC, 8'h02);
    far.wdg_pulse();
    wait2();
    `CHK("wdg_tl", 1'b1, tlpend)
    chk_ext();
    far.ack(8'h00, 9'h000, 1'b1);
    // watchdog to A0 only, top level from pin
    wr(PAGE_EXT, OFS_EXT_VEC, 8'h0c);
    far.wdg_pulse();
    wait2();
    m_ep = 8'h01;
    `CHK("wdg_a0", 1'b0, tlpend)
    chk_ext();
    far.ack(8'h01, 9'h000, 1'b0);
    m_ep = 8'h00;
    for (k = 1; k >= 0; k--) begin
      wr(PAGE_EXT, OFS_EXT_VEC, 8'h06 | 8'(k << 3));
      far.set_lines(8'h00, 9'h000, 1'b1);
      `CHK("nmi_rise", 1'(k), tlpend)
      far.set_lines(8'h00, 9'h000, 1'b0);
      `CHK("nmi_fall", 1'b1, tlpend)
      far.ack(8'h00, 9'h000, 1'b1);
    end
    wait_n = 1'b0;
    for (k = 0; k < 2; k++) begin
      wr(PAGE_EXT, OFS_EXT_VEC, 8'ha6 | 8'(k));
      repeat (4) @(negedge clk);
      `CHK("stretch", 1'(k), stretch)
    end
    wait_n = 1'b1;
    repeat (4) @(negedge clk);
    `CHK("stretch_off", 1'b0, stretch)
    // Top-level gating, then the set-only lock
    {gie, tlen} = 2'b01;
    @(negedge clk) tl_set = 1'b1;
    @(negedge clk) tl_set = 1'b0;
    wait2();
    `CHK("tl_masked", 1'b0, tlreq)
    gie = 1'b1;
    wait2();
    `CHK("tl_on", 1'b1, tlreq)
    gie = 1'b0;
    wr(PAGE_EXT, OFS_NEST, 8'h80);
    wr(PAGE_EXT, OFS_NEST, 8'h00);
    wait2();
    `CHK("tl_locked", 1'b1, tlreq)
    chk_rd("lock_kept", PAGE_EXT, OFS_NEST, 8'h80);
    @(negedge clk) rst_n = 1'b0;
    @(negedge clk) rst_n = 1'b1;
    chk_rd("lock_rst", PAGE_EXT, OFS_NEST, 8'h00);
    chk_rd("vec_kept", PAGE_EXT, OFS_EXT_VEC, 8'ha6);
    // Hold levels in nested mode, then with nesting off
    {gie, nested} = 2'b11;
    core_evt(3'd3, 1'b0, 1'b0);
    `CHK("hold_a", 7'h08, hold)
    core_evt(3'd5, 1'b1, 1'b0);
    `CHK("hold_tl", 7'h08, hold)
    core_evt(3'd1, 1'b0, 1'b0);
    `CHK("hold_b", 7'h0a, hold)
    core_evt(3'd3, 1'b0, 1'b1);
    `CHK("hold_iret", 7'h02, hold)
    nested = 1'b0;
    core_evt(3'd4, 1'b0, 1'b0);
    `CHK("hold_flat", 7'h02, hold)
    // Each standard channel with a random edge register
    for (i = 0; i < 9; i++) begin
      se = $random(seed);
      m_sm = 9'h001 << i;
      wr9(OFS_STD_EDGE_H, OFS_STD_EDGE_L, se);
      wr9(OFS_STD_MASK_H, OFS_STD_MASK_L, m_sm);
      far.set_lines(8'h00, 9'h001 << i, 1'b0);
      wait2();
      m_sp[i] = se[i];
      chk_std();
      far.set_lines(8'h00, 9'h000, 1'b0);
      wait2();
      m_sp[i] = 1'b1;
      chk_std();
      far.ack(8'h00, 9'h001 << i, 1'b0);
      m_sp = 9'h000;
      wait2();
      chk_std();
    end
    m_sm = 9'h1ff;
    wr9(OFS_STD_EDGE_H, OFS_STD_EDGE_L, m_sm);
    wr9(OFS_STD_MASK_H, OFS_STD_MASK_L, m_sm);
    fork
      far.set_lines(8'h00, 9'h001, 1'b0);
      begin
        @(negedge clk);
        {page, addr, wdata, wr_s} = {PAGE_STD, OFS_STD_EDGE_L, 8'hff, 1'b1};
        repeat (8) @(negedge clk);
        wr_s = 1'b0;
      end
    join
    wait2();
    chk_std();
    far.set_lines(8'h00, 9'h101, 1'b0);
    wait2();
    m_sp = 9'h100;
    chk_std();
    m_sp = 9'h0aa;
    wr9(OFS_STD_PEND_H, OFS_STD_PEND_L, m_sp);
    wait2();
    chk_std();
    summarize();
  end
endmodule
`default_nettype wire

// ### hdl/eisc_irq_ctrl.sv
// External and standard interrupt channels: edge detect, pending, masks,
// pair priorities, top-level source and lock, nested hold levels, wait pin.
// Assumes a register-file port with page select from the core, one-cycle
// acknowledge/iret pulses from the core, and a watchdog pulse on MCLK_IN.
// Behaviour
// - External pending set by edge, cleared by acknowledge.
// - Software writing one sets external pending.
// - External request needs mask, pending, global enable.
// - Pair priority bits D..A plus odd/even LSB.
// - Priority level 0 highest, 7 lowest.
// - Vector high nibble untouched by reset.
// - Top-level edge bit picks falling or rising.
// - Top-level source: watchdog at 0, pin at 1.
// - Channel A0 source: watchdog at 0, pin at 1.
// - Wait-enable bit gates the external wait pin.
// - Top-level lock is set-only, reset clears.
// - Lock makes top-level request need only pending.
// - Nested mode holds a level preempted by a non-top-level source until iret.
// - Standard I0 mask at high mask bit 0.
// - Standard E0..H1 masks in low mask register.
// - Standard edge bits pick falling or rising.
// - Standard edge during trigger-register write sets nothing.
// - Standard pending set by edge, cleared by ack.
// - External edge bits pick falling or rising.
// - Requests sampled every five core cycles.
`timescale 1ns/10ps
`default_nettype none
module eisc_irq_ctrl
  import eisc_pkg::*;
(
  input wire logic MCLK_IN, // Core clock, 125 MHz
  input wire logic RSTN_IN, // Async reset, active low
  input wire logic [7:0] REG_PAGE_IN, // Current register page
  input wire logic [7:0] REG_ADDR_IN, // Register address
  input wire logic REG_WR_IN, // Write strobe
  input wire logic REG_RD_IN, // Read strobe
  input wire logic [7:0] REG_WDATA_IN, // Write data
  output logic [7:0] REG_RDATA_OUT, // Read data, one cycle after strobe
  input wire logic [7:0] EXT_PIN_IN, // External lines A0..D1
  input wire logic [8:0] STD_LINE_IN, // Standard lines E0..H1, I0 at 8
  input wire logic NMI_PIN_IN, // Non-maskable input pin
  input wire logic MEM_WAIT_N_IN, // External memory wait pin
  input wire logic WDG_EOC_IN, // Watchdog end-of-count pulse
  input wire logic GLOBAL_IRQ_EN_IN, // Global maskable enable
  input wire logic TOPLEVEL_EN_IN, // Top-level enable
  input wire logic TL_SW_SET_IN, // Software set of top-level pending
  input wire logic TL_ACK_IN, // Top-level acknowledge pulse
  input wire logic [7:0] EXT_ACK_IN, // External acknowledge pulses
  input wire logic [8:0] STD_ACK_IN, // Standard acknowledge pulses
  input wire logic NESTED_MODE_IN, // Nested arbitration mode
  input wire logic PREEMPT_IN, // Running routine was preempted
  input wire logic PREEMPT_BY_TL_IN, // Preemption came from top level
  input wire logic [2:0] PREEMPT_LEVEL_IN, // Level of preempted routine
  input wire logic IRET_IN, // Iret resumes a routine
  input wire logic [2:0] IRET_LEVEL_IN, // Level being resumed
  output logic [7:0] EXT_REQ_OUT, // Sampled external requests
  output logic [8:0] STD_REQ_OUT, // Sampled standard requests
  output logic [23:0] EXT_PRIO_OUT, // 3-bit level per external channel
  output logic [2:0] EXT_BEST_LEVEL_OUT, // Best sampled external level
  output logic TL_REQ_OUT, // Sampled top-level request
  output logic TL_PENDING_OUT, // Top-level pending flag
  output logic [6:0] HOLD_LEVEL_OUT, // Hold-level bits
  output logic SAMPLE_TICK_OUT, // Arbitration sample strobe
  output logic MEM_STRETCH_OUT // Stretch external memory cycle
);

  logic [PIN_W-1:0] s1_r, s2_r, s3_r, lvl_r, lvl_nxt;
  logic [PIN_W-1:0] acc, rise, fall;
  logic [7:0] ext_edge_r, ext_pend_r, ext_mask_r, ext_prio_r;
  logic [7:0] ext_edge_nxt, ext_pend_nxt, ext_mask_nxt, ext_prio_nxt;
  logic [3:0] cfg_r, cfg_nxt, vec_r;
  logic lock_r, lock_nxt, tl_pend_r, tl_pend_nxt;
  logic [6:0] hold_r, hold_nxt;
  logic [8:0] std_mask_r, std_edge_r, std_pend_r;
  logic [8:0] std_mask_nxt, std_edge_nxt, std_pend_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic tick;
  logic [7:0] ext_req_r, ext_req_nxt;
  logic [8:0] std_req_r, std_req_nxt;
  logic tl_req_r, tl_req_nxt;
  logic [2:0] best_r, best_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [7:0] ext_evt, ext_hit;
  logic [8:0] std_evt, std_hit;
  logic nmi_evt, tl_hit, pg_ext, pg_std, edge_wr;
  logic wr_ext_pend, wr_std_pend;
  logic [23:0] prio_all;

  // Pin synchroniser: three stages, a change counts once stages 2 and 3
  // agree, which also filters single-cycle glitches on the lines.
  always_comb begin
    acc = ~(s2_r ^ s3_r);
    lvl_nxt = (s3_r & acc) | (lvl_r & ~acc);
    rise = acc & s3_r & ~lvl_r;
    fall = acc & ~s3_r & lvl_r;
  end

  always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      lvl_r <= '0;
    end else begin
      s1_r <= {MEM_WAIT_N_IN, NMI_PIN_IN, STD_LINE_IN, EXT_PIN_IN};
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end

  // Page decode and trigger events
  always_comb begin
    pg_ext = (REG_PAGE_IN == PAGE_EXT);
    pg_std = (REG_PAGE_IN == PAGE_STD);
    ext_evt = (rise[7:0] & ext_edge_r) | (fall[7:0] & ~ext_edge_r);
    std_evt = (rise[16:PIN_STD] & std_edge_r) |
              (fall[16:PIN_STD] & ~std_edge_r);
    nmi_evt = cfg_r[BIT_TL_EDGE] ? rise[PIN_NMI] : fall[PIN_NMI];
    ext_hit = {ext_evt[7:1],
               cfg_r[BIT_A0_SRC] ? ext_evt[0] : WDG_EOC_IN};
    tl_hit = cfg_r[BIT_TL_SRC] ? nmi_evt : WDG_EOC_IN;
    edge_wr = REG_WR_IN && pg_std &&
              (REG_ADDR_IN == OFS_STD_EDGE_H ||
               REG_ADDR_IN == OFS_STD_EDGE_L);
    std_hit = edge_wr ? 9'h000 : std_evt;
    wr_ext_pend = REG_WR_IN && pg_ext && REG_ADDR_IN == OFS_EXT_PEND;
    wr_std_pend = REG_WR_IN && pg_std &&
                  (REG_ADDR_IN == OFS_STD_PEND_H ||
                   REG_ADDR_IN == OFS_STD_PEND_L);
  end

  // Register file next values; a hardware set always wins over a clear
  always_comb begin
    ext_edge_nxt = ext_edge_r;
    ext_mask_nxt = ext_mask_r;
    ext_prio_nxt = ext_prio_r;
    cfg_nxt = cfg_r;
    std_mask_nxt = std_mask_r;
    std_edge_nxt = std_edge_r;
    // set by edge, clear on ack
    ext_pend_nxt = (ext_pend_r & ~EXT_ACK_IN) | ext_hit;
    std_pend_nxt = (std_pend_r & ~STD_ACK_IN) | std_hit;
    lock_nxt = lock_r;
    tl_pend_nxt = (tl_pend_r & ~TL_ACK_IN) | tl_hit | TL_SW_SET_IN;
    if (REG_WR_IN && pg_ext) begin
      case (REG_ADDR_IN)
        OFS_EXT_EDGE: ext_edge_nxt = REG_WDATA_IN;
        OFS_EXT_PEND: ext_pend_nxt = REG_WDATA_IN | ext_hit;
        OFS_EXT_MASK: ext_mask_nxt = REG_WDATA_IN;
        OFS_EXT_PRIO: ext_prio_nxt = REG_WDATA_IN;
        OFS_EXT_VEC: cfg_nxt = REG_WDATA_IN[3:0];
        OFS_NEST: lock_nxt = lock_r | REG_WDATA_IN[BIT_TL_LOCK];
        default: ;
      endcase
    end
    if (REG_WR_IN && pg_std) begin
      case (REG_ADDR_IN)
        OFS_STD_MASK_H: std_mask_nxt[8] = REG_WDATA_IN[0];
        OFS_STD_MASK_L: std_mask_nxt[7:0] = REG_WDATA_IN;
        OFS_STD_EDGE_H: std_edge_nxt[8] = REG_WDATA_IN[0];
        OFS_STD_EDGE_L: std_edge_nxt[7:0] = REG_WDATA_IN;
        OFS_STD_PEND_H: std_pend_nxt[8] = REG_WDATA_IN[0] | std_hit[8];
        OFS_STD_PEND_L: std_pend_nxt[7:0] = REG_WDATA_IN | std_hit[7:0];
        default: ;
      endcase
    end
  end

  // Hold levels: iret clears the resumed level, a nested-mode preemption not from top level sets one
  always_comb begin
    hold_nxt = hold_r;
    if (IRET_IN && IRET_LEVEL_IN != LEVEL_LOWEST) begin
      hold_nxt[IRET_LEVEL_IN] = 1'b0;
    end
    if (PREEMPT_IN && NESTED_MODE_IN && !PREEMPT_BY_TL_IN &&
        PREEMPT_LEVEL_IN != LEVEL_LOWEST) begin
      hold_nxt[PREEMPT_LEVEL_IN] = 1'b1;
    end
  end

  // Per-channel level: two written bits and the odd/even channel bit
  for (genvar i = 0; i < 8; i++) begin : g_prio
    assign prio_all[3*i +: 3] = {ext_prio_r[2*(i/2) +: 2], 1'(i % 2)};
  end

  // Sampling divider and sampled requests
  always_comb begin
    tick = (cnt_r == SAMPLE_LAST);
    cnt_nxt = tick ? 3'h0 : cnt_r + 3'h1;
    ext_req_nxt = ext_req_r;
    std_req_nxt = std_req_r;
    tl_req_nxt = tl_req_r;
    best_nxt = best_r;
    if (tick) begin
      ext_req_nxt = ext_mask_r & ext_pend_r & {8{GLOBAL_IRQ_EN_IN}};
      std_req_nxt = std_mask_r & std_pend_r & {9{GLOBAL_IRQ_EN_IN}};
      tl_req_nxt = tl_pend_r &
                   (lock_r | (GLOBAL_IRQ_EN_IN & TOPLEVEL_EN_IN));
      best_nxt = LEVEL_LOWEST;
      for (int k = 7; k >= 0; k--) begin
        if (ext_req_nxt[k] && prio_all[3*k +: 3] <= best_nxt) begin
          best_nxt = prio_all[3*k +: 3];
        end
      end
    end
  end

  // Read mux; reserved bits read as zero
  always_comb begin
    rdata_nxt = rdata_r;
    if (REG_RD_IN) begin
      rdata_nxt = 8'h00;
      if (pg_ext) begin
        case (REG_ADDR_IN)
          OFS_EXT_EDGE: rdata_nxt = ext_edge_r;
          OFS_EXT_PEND: rdata_nxt = ext_pend_r;
          OFS_EXT_MASK: rdata_nxt = ext_mask_r;
          OFS_EXT_PRIO: rdata_nxt = ext_prio_r;
          OFS_EXT_VEC: rdata_nxt = {vec_r, cfg_r};
          OFS_NEST: rdata_nxt = {lock_r, hold_r};
          default: rdata_nxt = 8'h00;
        endcase
      end else if (pg_std) begin
        case (REG_ADDR_IN)
          OFS_STD_MASK_H: rdata_nxt = {7'h00, std_mask_r[8]};
          OFS_STD_MASK_L: rdata_nxt = std_mask_r[7:0];
          OFS_STD_EDGE_H: rdata_nxt = {7'h00, std_edge_r[8]};
          OFS_STD_EDGE_L: rdata_nxt = std_edge_r[7:0];
          OFS_STD_PEND_H: rdata_nxt = {7'h00, std_pend_r[8]};
          OFS_STD_PEND_L: rdata_nxt = std_pend_r[7:0];
          default: rdata_nxt = 8'h00;
        endcase
      end
    end
  end

  // State registers
  always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      ext_edge_r <= 8'h00;
      ext_pend_r <= 8'h00;
      ext_mask_r <= 8'h00;
      ext_prio_r <= RST_EXT_PRIO;
      cfg_r <= RST_EXT_CFG;
      lock_r <= 1'b0;
      tl_pend_r <= 1'b0;
      hold_r <= 7'h00;
      std_mask_r <= 9'h000;
      std_edge_r <= 9'h000;
      std_pend_r <= 9'h000;
      cnt_r <= 3'h0;
      ext_req_r <= 8'h00;
      std_req_r <= 9'h000;
      tl_req_r <= 1'b0;
      best_r <= LEVEL_LOWEST;
      rdata_r <= 8'h00;
    end else begin
      ext_edge_r <= ext_edge_nxt;
      ext_pend_r <= ext_pend_nxt;
      ext_mask_r <= ext_mask_nxt;
      ext_prio_r <= ext_prio_nxt;
      cfg_r <= cfg_nxt;
      lock_r <= lock_nxt;
      tl_pend_r <= tl_pend_nxt;
      hold_r <= hold_nxt;
      std_mask_r <= std_mask_nxt;
      std_edge_r <= std_edge_nxt;
      std_pend_r <= std_pend_nxt;
      cnt_r <= cnt_nxt;
      ext_req_r <= ext_req_nxt;
      std_req_r <= std_req_nxt;
      tl_req_r <= tl_req_nxt;
      best_r <= best_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Vector nibble has no reset, so software must load it before use
  // vector kept over reset
  always_ff @(posedge MCLK_IN) begin
    if (REG_WR_IN && pg_ext && REG_ADDR_IN == OFS_EXT_VEC) begin
      vec_r <= REG_WDATA_IN[7:4];
    end
  end

  // Outputs
  assign REG_RDATA_OUT = rdata_r;
  assign EXT_REQ_OUT = ext_req_r;
  assign STD_REQ_OUT = std_req_r;
  assign EXT_PRIO_OUT = prio_all;
  assign EXT_BEST_LEVEL_OUT = best_r;
  assign TL_REQ_OUT = tl_req_r;
  assign TL_PENDING_OUT = tl_pend_r;
  assign HOLD_LEVEL_OUT = hold_r;
  assign SAMPLE_TICK_OUT = tick;
  assign MEM_STRETCH_OUT = cfg_r[BIT_WAIT_EN] & ~s3_r[PIN_WAIT];

  // Checks
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!RSTN_IN);

  property p_ext_set;
    (ext_hit != 8'h00) |=> ((ext_pend_r & $past(ext_hit)) == $past(ext_hit));
  endproperty
  a_ext_set: assert property (p_ext_set)
    else $error("ext set lost");
  property p_ext_ack;
    (!wr_ext_pend && (EXT_ACK_IN & ~ext_hit) != 8'h00)
      |=> ((ext_pend_r & $past(EXT_ACK_IN & ~ext_hit)) == 8'h00);
  endproperty
  a_ext_ack: assert property (p_ext_ack) else $error("ack kept");
  property p_sw_set;
    wr_ext_pend |=>
      ((ext_pend_r & $past(REG_WDATA_IN)) == $past(REG_WDATA_IN));
  endproperty
  a_sw_set: assert property (p_sw_set) else $error("sw set lost");
  property p_ext_req;
    tick |=> (EXT_REQ_OUT ==
              $past(ext_mask_r & ext_pend_r & {8{GLOBAL_IRQ_EN_IN}}));
  endproperty
  a_ext_req: assert property (p_ext_req) else $error("ext req bad");
  property p_lock;
    lock_r |=> lock_r;
  endproperty
  a_lock: assert property (p_lock) else $error("lock cleared");
  property p_tl_req;
    (tick && lock_r && tl_pend_r) |=> TL_REQ_OUT;
  endproperty
  a_tl_req: assert property (p_tl_req) else $error("tl req lost");
  property p_edge_wr;
    (edge_wr && !wr_std_pend) |=> ((std_pend_r & ~$past(std_pend_r)) == 9'h0);
  endproperty
  a_edge_wr: assert property (p_edge_wr)
    else $error("set in write");
  property p_tick;
    tick |=> !tick [*4] ##1 tick;
  endproperty
  a_tick: assert property (p_tick) else $error("tick period");
  property p_wait;
    !cfg_r[BIT_WAIT_EN] |-> !MEM_STRETCH_OUT;
  endproperty
  a_wait: assert property (p_wait) else $error("wait not gated");

  c_ext_req: cover property (tick ##1 EXT_REQ_OUT != 8'h00);
  c_tl_req: cover property (tl_hit ##[1:10] TL_REQ_OUT);
  c_hold: cover property (PREEMPT_IN && NESTED_MODE_IN ##[1:20] IRET_IN);

endmodule
`default_nettype wire

// ### hdl/eisc_pkg.sv
// Package for the external and standard interrupt channel block.
// Holds the register map, page numbers, reset values and timing counts.
package eisc_pkg;
  // Register pages that steer the shared addresses
  localparam logic [7:0] PAGE_EXT = 8'h00;
  localparam logic [7:0] PAGE_STD = 8'h3c;
  // Page of the external channels
  localparam logic [7:0] OFS_EXT_EDGE = 8'hf2;
  localparam logic [7:0] OFS_EXT_PEND = 8'hf3;
  localparam logic [7:0] OFS_EXT_MASK = 8'hf4;
  localparam logic [7:0] OFS_EXT_PRIO = 8'hf5;
  localparam logic [7:0] OFS_EXT_VEC = 8'hf6;
  localparam logic [7:0] OFS_NEST = 8'hf7;
  // Page of the standard channels
  localparam logic [7:0] OFS_STD_MASK_H = 8'hf5;
  localparam logic [7:0] OFS_STD_MASK_L = 8'hf6;
  localparam logic [7:0] OFS_STD_EDGE_H = 8'hf7;
  localparam logic [7:0] OFS_STD_EDGE_L = 8'hf8;
  localparam logic [7:0] OFS_STD_PEND_H = 8'hf9;
  localparam logic [7:0] OFS_STD_PEND_L = 8'hfa;
  // Reset values
  localparam logic [7:0] RST_EXT_PRIO = 8'hff;
  localparam logic [3:0] RST_EXT_CFG = 4'h6;
  // Bit positions inside the vector/config register; the lock bit is in the nest register
  localparam int BIT_WAIT_EN = 0;
  localparam int BIT_A0_SRC = 1;
  localparam int BIT_TL_SRC = 2;
  localparam int BIT_TL_EDGE = 3;
  localparam int BIT_TL_LOCK = 7;
  // Request sampling period in core clock cycles
  localparam int SAMPLE_PERIOD = 5;
  localparam logic [2:0] SAMPLE_LAST = 3'(SAMPLE_PERIOD - 1);
  // Synchronised pin vector layout
  localparam int PIN_STD = 8;
  localparam int PIN_NMI = 17;
  localparam int PIN_WAIT = 18;
  localparam int PIN_W = 19;
  localparam logic [2:0] LEVEL_LOWEST = 3'h7;
endpackage
